// >>> design/gac_channel.sv
// Purpose: one amplifier channel: clock event select, enable hold, comparator clock
// Assumes: event inputs are one-cycle pulses on mclk
// Notes: identical for all three amplifiers
`timescale 1ns/10ps
module gac_channel (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] ctrl,
   input wire logic [7:0] events,
   input wire logic conv_busy,
   output logic amp_on,
   output logic sync_pulse,
   output logic cmp_clk_pulse
);
   typedef enum logic [1:0] {gac_ch_off, gac_ch_on, gac_ch_drain} gac_ch_state_t;
   gac_ch_state_t state_r, state_nxt;
   logic [2:0] sel;
   logic sel_evt;
   logic half_r;
   logic [15:0] gap_r;
   logic mid_hit;

   // pick the selected event; RULE_11 and RULE_12 share the table
   assign sel = ctrl[gac_pkg::gac_sel_hi:gac_pkg::gac_sel_lo];
   assign sel_evt = events[sel];

   // RULE_04 disable waits for conversion end
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         gac_ch_off: if (ctrl[gac_pkg::gac_bit_on]) state_nxt = gac_ch_on;
         gac_ch_on: if (!ctrl[gac_pkg::gac_bit_on]) begin
            state_nxt = conv_busy ? gac_ch_drain : gac_ch_off;
         end
         gac_ch_drain: begin
            if (ctrl[gac_pkg::gac_bit_on]) state_nxt = gac_ch_on;
            else if (!conv_busy) state_nxt = gac_ch_off;
         end
         default: state_nxt = gac_ch_off;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) state_r <= gac_ch_off;
      else state_r <= state_nxt;
   end

   // RULE_03 on while running or draining
   assign amp_on = (state_r != gac_ch_off);
   // RULE_16 single-cycle sync pulse
   assign sync_pulse = amp_on && sel_evt;

   // measure event spacing so a mid-period tick can be placed
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         gap_r <= 16'h0000;
         half_r <= 1'b0;
      end else if (sync_pulse) begin
         gap_r <= 16'h0000;
         half_r <= 1'b0;
      end else begin
         if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
         if (mid_hit) half_r <= 1'b1;
      end
   end

   // period estimate is the last gap; first period after enable gives one tick only
   logic [15:0] last_gap_r;
   always_ff @(posedge mclk) begin
      if (!rst_n) last_gap_r <= 16'h0000;
      else if (sync_pulse) last_gap_r <= gap_r;
   end
   assign mid_hit = !half_r && (last_gap_r != 16'h0000) && (gap_r == (last_gap_r >> 1));

   // RULE_10 comparator ticks twice per amp clock
   assign cmp_clk_pulse = ctrl[gac_pkg::gac_bit_cmp] && amp_on && (sync_pulse || mid_hit);
endmodule // gac_channel

// >>> design/gac_pkg.sv
// Purpose: shared constants for the gain amplifier control block
// Assumes: APB slave, 32-bit data, one word per register
// Notes: register offsets are byte addresses
package gac_pkg;
   localparam int gac_num_amps = 3;
   // register byte offsets
   localparam logic [11:0] gac_off_amp0 = 12'h000;
   localparam logic [11:0] gac_off_amp1 = 12'h004;
   localparam logic [11:0] gac_off_amp2 = 12'h008;
   localparam logic [11:0] gac_off_status = 12'h00c;
   localparam logic [7:0] gac_ctrl_reset = 8'h00;
   // control field positions
   localparam int gac_bit_on = 7;
   localparam int gac_bit_short = 6;
   localparam int gac_gain_hi = 5;
   localparam int gac_gain_lo = 4;
   localparam int gac_bit_cmp = 3;
   localparam int gac_sel_hi = 2;
   localparam int gac_sel_lo = 0;
   // converter clock divider for the /8 amplifier clock
   localparam int gac_div_ratio = 8;
   // software-start conversion lengths in converter clocks, by divided clock phase
   localparam logic [4:0] gac_len_short = 5'h0d;
   localparam logic [4:0] gac_len_long = 5'h0e;
   // clock source codes
   typedef enum logic [2:0] {
      gac_src_adc_div8 = 3'h0,
      gac_src_t0_cmp = 3'h1,
      gac_src_t0_ovf = 3'h2,
      gac_src_t1_cmpb = 3'h3,
      gac_src_t1_ovf = 3'h4,
      gac_src_power_stage_sync_zero = 3'h5,
      gac_src_power_stage_sync_one = 3'h6,
      gac_src_power_stage_sync_two = 3'h7
   } gac_src_t;
   // gain codes
   typedef enum logic [1:0] {
      gac_gain_5 = 2'h0,
      gac_gain_10 = 2'h1,
      gac_gain_20 = 2'h2,
      gac_gain_40 = 2'h3
   } gac_gain_t;
endpackage

// >>> design/gac_top.sv
// Purpose: control of three programmable-gain amplifiers ahead of the converter
// Assumes: APB slave, synchronous inputs, one clock mclk at 250 MHz
// Notes: the analog path itself is outside; this block drives its controls
// Functional notes
// RULE_01 - one 8-bit read/write control register per amplifier, reset zero
// RULE_02 - same layout for all three; each controls only its own amplifier
// RULE_03 - bit 7 one switches the amplifier on, zero switches it off
// RULE_04 - clearing enable mid-conversion takes effect when conversion ends
// RULE_05 - software clears selector low bits together with enable
// RULE_06 - bit 6 one shorts the amplifier input
// RULE_07 - gain field 00/01/10/11 gives gain 5/10/20/40
// RULE_08 - outside keeps input stable four sync periods after gain change
// RULE_09 - bit 3 one routes amplifier output to its comparator positive input
// RULE_10 - connected comparator clocks at twice the amplifier sync rate
// RULE_11 - selector 000..100: converter/8, t0 compare, t0 overflow, t1 cmpB, t1 overflow
// RULE_12 - selector 101..111: power-stage sync zero, one, two
// RULE_13 - amplified conversion starts only on the selected clock event
// RULE_14 - software start with divided clock: 13 clocks if low, 14 if high
// RULE_15 - auto trigger starts at first amp event after latest trigger
// RULE_16 - each selected source becomes a single-cycle sync pulse
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module gac_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic adc_clk_en,
   input wire logic timer0_cmp,
   input wire logic timer0_ovf,
   input wire logic timer1_cmpb,
   input wire logic timer1_ovf,
   input wire logic power_stage_sync_zero,
   input wire logic power_stage_sync_one,
   input wire logic power_stage_sync_two,
   input wire logic [1:0] conv_channel,
   input wire logic conv_soft_start,
   input wire logic conv_auto_trig,
   input wire logic conv_done,
   output logic [2:0] amp_on,
   output logic [2:0] amp_input_short,
   output logic [5:0] amp_gain,
   output logic [2:0] amp_to_comparator,
   output logic [2:0] amp_sync,
   output logic [2:0] comparator_clk,
   output logic conv_start,
   output logic [4:0] conv_length,
   output logic conv_busy,
   output logic divided_converter_clock
);
   localparam int n = gac_pkg::gac_num_amps;
   logic [7:0] ctrl_r [n];
   logic [2:0] div_r;
   logic div8_pulse;
   logic [7:0] events;
   logic [2:0] sync_w;
   logic [2:0] cmp_w;
   logic [2:0] on_w;
   logic wr_en;
   logic rd_en;
   logic [2:0] hit;
   logic hit_status;
   logic busy_r;
   logic pend_r;
   logic pend_nxt;
   logic [1:0] chan_r;
   logic start_w;
   logic [31:0] rdata_nxt;

   // converter clock divided by eight; high half marks the slow phase
   always_ff @(posedge mclk) begin
      if (!rst_n) div_r <= 3'h0;
      else if (adc_clk_en) div_r <= div_r + 3'h1;
   end
   assign div8_pulse = adc_clk_en && (div_r == 3'h7);
   assign divided_converter_clock = div_r[2];

   // RULE_11 source table order
   assign events = {power_stage_sync_two, power_stage_sync_one, power_stage_sync_zero,
                    timer1_ovf, timer1_cmpb, timer0_ovf, timer0_cmp, div8_pulse};

   // RULE_02 one identical channel per amplifier
   for (genvar i = 0; i < n; i++) begin : g_ch
      gac_channel u_ch (
         .mclk(mclk),
         .rst_n(rst_n),
         .ctrl(ctrl_r[i]),
         .events(events),
         .conv_busy(busy_r && (chan_r == 2'(i))),
         .amp_on(on_w[i]),
         .sync_pulse(sync_w[i]),
         .cmp_clk_pulse(cmp_w[i])
      );
   end

   // apb decode, zero-wait slave
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign hit[0] = (paddr == gac_pkg::gac_off_amp0);
   assign hit[1] = (paddr == gac_pkg::gac_off_amp1);
   assign hit[2] = (paddr == gac_pkg::gac_off_amp2);
   assign hit_status = (paddr == gac_pkg::gac_off_status);
   assign pready = 1'b1;
   // unmapped addresses answer with an error, reads give zero
   assign pslverr = psel && penable && !(|hit || (hit_status && !pwrite));

   // RULE_01 control registers, all bits writable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int k = 0; k < n; k++) ctrl_r[k] <= gac_pkg::gac_ctrl_reset;
      end else if (wr_en) begin
         for (int k = 0; k < n; k++) if (hit[k]) ctrl_r[k] <= pwdata[7:0];
      end
   end

   // read mux; status shows live amplifier and converter state
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit[0]) rdata_nxt = {24'h000000, ctrl_r[0]};
      else if (hit[1]) rdata_nxt = {24'h000000, ctrl_r[1]};
      else if (hit[2]) rdata_nxt = {24'h000000, ctrl_r[2]};
      else if (hit_status) rdata_nxt = {24'h000000, pend_r, busy_r, chan_r, 1'b0, on_w};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) prdata <= 32'h0000_0000;
      else if (rd_en) prdata <= rdata_nxt;
   end

   // analog controls from flops
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         amp_input_short <= 3'h0;
         amp_gain <= 6'h00;
         amp_to_comparator <= 3'h0;
         amp_on <= 3'h0;
         amp_sync <= 3'h0;
         comparator_clk <= 3'h0;
      end else begin
         for (int k = 0; k < n; k++) begin
            // RULE_06 input shunt
            amp_input_short[k] <= ctrl_r[k][gac_pkg::gac_bit_short];
            // RULE_07 gain code to analog
            amp_gain[2*k +: 2] <= ctrl_r[k][gac_pkg::gac_gain_hi:gac_pkg::gac_gain_lo];
            // RULE_09 comparator routing
            amp_to_comparator[k] <= ctrl_r[k][gac_pkg::gac_bit_cmp];
         end
         amp_on <= on_w;
         amp_sync <= sync_w;
         comparator_clk <= cmp_w;
      end
   end

   // RULE_13 RULE_15 pending request waits for amp event
   assign pend_nxt = (pend_r || conv_soft_start || conv_auto_trig) && !start_w;
   assign start_w = (pend_r || conv_soft_start || conv_auto_trig) && !busy_r
                    && (conv_channel < 2'h3) && sync_w[conv_channel];

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
         busy_r <= 1'b0;
         chan_r <= 2'h0;
         conv_start <= 1'b0;
         conv_length <= 5'h00;
      end else begin
         pend_r <= pend_nxt;
         conv_start <= start_w;
         if (start_w) begin
            busy_r <= 1'b1;
            chan_r <= conv_channel;
         end else if (conv_done) begin
            busy_r <= 1'b0;
         end
         // RULE_14 length by divided clock phase
         if (conv_soft_start) begin
            conv_length <= divided_converter_clock ? gac_pkg::gac_len_long
                                                   : gac_pkg::gac_len_short;
         end
      end
   end
   assign conv_busy = busy_r;
endmodule // gac_top

// >>> verif/gac_conv_model.sv
// Purpose: converter stand-in that closes conversions
// Assumes: conv_start is a one-cycle pulse
// Notes: dly sets the conversion length in mclk cycles
`timescale 1ns/10ps
module gac_conv_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [4:0] dly,
   input wire logic conv_start,
   output logic conv_done
);
   logic [4:0] cnt_r;
   // only a start opens a conversion
   always_ff @(posedge mclk) begin
      conv_done <= 1'h0;
      if (!rst_n) cnt_r <= 5'h0;
      else if (conv_start) cnt_r <= dly;
      else if (cnt_r != 5'h0) begin
         cnt_r <= cnt_r - 5'h1;
         conv_done <= (cnt_r == 5'h1);
      end
   end
endmodule // gac_conv_model

// >>> verif/gac_top_chk.sv
// Purpose: port assertions for the amplifier control
// Assumes: one clock, synchronous active-low reset
// Notes: amplifiers zero and two stand for all three
`timescale 1ns/10ps
module gac_top_chk (
   input wire logic mclk, rst_n, psel, penable, pwrite, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] amp_on, amp_input_short, amp_to_comparator,
   input wire logic [2:0] amp_sync, comparator_clk,
   input wire logic [5:0] amp_gain,
   input wire logic [4:0] conv_length,
   input wire logic [1:0] conv_channel,
   input wire logic conv_start, conv_busy, conv_done, conv_soft_start, divided_converter_clock
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // write to amplifier zero, taken in access phase
   wire logic w0 = psel & penable & pwrite & (paddr == gac_pkg::gac_off_amp0);
   // register, channel state and output flop: three edges from the write
   property p_on; w0 & pwdata[7] |-> ##3 amp_on[0]; endproperty
   a_on: assert property (p_on) else $error("enable lost");
   property p_fld; w0 |-> ##2 {amp_input_short[0], amp_gain[1:0], amp_to_comparator[0]}
      == $past(pwdata[6:3], 2); endproperty
   a_fld: assert property (p_fld) else $error("field lost");
   property p_err; psel & penable & (paddr > gac_pkg::gac_off_status) |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no error");
   property p_sync; amp_sync[0] |-> amp_on[0]; endproperty
   a_sync: assert property (p_sync) else $error("sync while off");
   property p_start; conv_start |-> (|amp_sync) ##1 conv_busy; endproperty
   a_start: assert property (p_start) else $error("start off event");
   property p_len; conv_soft_start |=> conv_length
      == ($past(divided_converter_clock) ? 5'h0e : 5'h0d); endproperty
   a_len: assert property (p_len) else $error("bad length");
   // a disable must wait for the running conversion
   property p_hold; amp_on[0] & conv_busy & !conv_done & (conv_channel == 2'h0)
      |=> amp_on[0]; endproperty
   a_hold: assert property (p_hold) else $error("early off");
   property p_cmp; amp_sync[2] & amp_to_comparator[2] |-> comparator_clk[2]; endproperty
   a_cmp: assert property (p_cmp) else $error("no cmp tick");
endmodule // gac_top_chk
bind gac_top gac_top_chk i_chk (.*);

// >>> verif/gain_amplifier_control_tb_top.sv
// Purpose: self-checking bench for the amplifier control
// Assumes: one-cycle APB access, converter model closes work
// Notes: monitor samples on the falling edge, clear of races
`timescale 1ns/10ps
module gain_amplifier_control_tb_top;
   logic mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic adc_clk_en = 1'h1, conv_soft_start = 1'h0, conv_auto_trig = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0] conv_channel = 2'h0;
   logic [7:1] ev = 7'h0;
   logic [4:0] dly = 5'h14, conv_length;
   logic pready, pslverr, conv_done, conv_start, conv_busy, divided_converter_clock;
   logic [2:0] amp_on, amp_input_short, amp_to_comparator, amp_sync, comparator_clk;
   logic [5:0] amp_gain;
   wire logic timer0_cmp, timer0_ovf, timer1_cmpb, timer1_ovf;
   wire logic power_stage_sync_zero, power_stage_sync_one, power_stage_sync_two;
   int err_count = 0, compares = 0, ns0 = 0, ns1 = 0, nc2 = 0, nst = 0;
   logic [31:0] q[$];
   int lq[$];
   // event pulses fan out to timer and power-stage inputs
   assign {power_stage_sync_two, power_stage_sync_one, power_stage_sync_zero, timer1_ovf,
      timer1_cmpb, timer0_ovf, timer0_cmp} = ev;
   gac_top i_dut (.*);
   gac_conv_model i_conv (.mclk(mclk), .rst_n(rst_n), .dly(dly), .conv_start(conv_start),
      .conv_done(conv_done));
   always #2 mclk = ~mclk;
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task stop_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one transfer from a rising edge, then an idle cycle
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1'h1;
      @(posedge mclk);
      while (pready !== 1'h1) @(posedge mclk);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      q.push_back(e);
      apb(1'h0, a, 32'h0);
   endtask
   task pulse(input logic [7:1] m, input int k);
      repeat (k) begin
         ev <= m;
         @(posedge mclk) ev <= 7'h0;
         @(posedge mclk);
      end
   endtask
   // falling-edge monitor: queued reads, lengths, counters
   always @(negedge mclk) begin
      if (psel && penable && !pwrite) chk("prdata", q.pop_front(), prdata);
      if (psel && penable) chk("pslverr", 32'((paddr > 12'h00c) || (paddr == 12'h00c && pwrite)),
         32'(pslverr));
      if (conv_start === 1'h1 && lq.size() > 0) chk("length", lq.pop_front(), conv_length);
      ns0 += amp_sync[0];
      ns1 += amp_sync[1];
      nc2 += comparator_clk[2];
      nst += conv_start;
   end
   // hang guard, far beyond the run length
   initial begin
      #40000;
      err_count++;
      stop_test;
   end
   initial begin
      logic [7:0] v, m;
      int b, c, j;
      v = 8'($urandom(81942));
      repeat (20) @(posedge mclk);
      rst_n <= 1'h1;
      @(posedge mclk);
      for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
      // enable kept off, selector low bits clear
      // no analog input moves after gain changes
      for (int i = 0; i < 4; i++) begin
         j = i % 3;
         v = 8'($urandom) & 8'h7c;
         v[5:4] = 2'(i);
         apb(1'h1, 12'(4 * j), {24'($urandom), v});
         rd(12'(4 * j), {24'h0, v});
         chk("fields", v[6:3], {amp_input_short[j], amp_gain[2 * j +: 2],
            amp_to_comparator[j]});
      end
      c = ns1;
      for (int s = 0; s < 8; s++) begin
         m = 8'h1 << s;
         apb(1'h1, 12'h0, {24'h0, 8'h80 | 8'(s)});
         repeat (2) @(posedge mclk);
         b = ns0;
         pulse(~m[7:1], 8);
         chk("foreign sync", (s == 0) ? 2 : 0, ns0 - b);
         b = ns0;
         pulse(m[7:1], 1);
         repeat (2) @(posedge mclk);
         if (s > 0) chk("own sync", 1, ns0 - b);
      end
      chk("amp one sync", 0, ns1 - c);
      apb(1'h1, 12'h0, 32'h83);
      b = nst;
      conv_auto_trig <= 1'h1;
      @(posedge mclk) conv_auto_trig <= 1'h0;
      pulse(7'h7b, 4);
      chk("early start", 0, nst - b);
      pulse(7'h04, 1);
      repeat (2) @(posedge mclk);
      chk("start", 1, nst - b);
      // selector low bits cleared with enable
      apb(1'h1, 12'h0, 32'h0);
      chk("held on", 1, amp_on[0]);
      while (conv_busy !== 1'h0) @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk("off", 0, amp_on[0]);
      apb(1'h1, 12'h0, 32'h80);
      for (int k = 0; k < 6; k++) begin
         dly <= 5'(2 + $urandom % 24);
         repeat ($urandom % 8) @(posedge mclk);
         b = nst;
         conv_soft_start <= 1'h1;
         // phase that the design samples at the next rising edge
         @(negedge mclk) lq.push_back(divided_converter_clock ? 14 : 13);
         @(posedge mclk) conv_soft_start <= 1'h0;
         while (nst == b) @(posedge mclk);
         while (conv_busy !== 1'h0) @(posedge mclk);
      end
      apb(1'h1, 12'h8, 32'h8d);
      repeat (2) @(posedge mclk);
      b = nc2;
      for (int k = 0; k < 4; k++) begin
         pulse(7'h10, 1);
         repeat (6) @(posedge mclk);
      end
      chk("cmp ticks", 7, nc2 - b);
      stop_test;
   end
endmodule // gain_amplifier_control_tb_top
